// File: rtl/cfe_event_supervisor.sv
`timescale 1ns/1ps
`include "cfe_map.svh"
// Function
// - cool when chamber above max setpoint and bypass has finished
// - cooling entry from idle blocked by cold coil or enabled bypass with hot inlet
// - cooling ends below max minus deadband or on cold coil
// - bypass when enabled, chamber below max and inlet above setpoint
// - no bypass when disabled, inlet cold or inlet sensor failed
// - bypass ends on cold inlet or when supply delay elapses
// - each sensor fault after out-of-range alarm time; clears when valid
// - probe A low alarm after low alarm time while enabled
// - probe A low alarm ends above setpoint or when disabled
// - probe A high alarm after high alarm time while enabled
// - probe A high alarm ends below setpoint or when disabled
// - probe B low and high alarms behave the same way
// - cooling time alarm after long cooling; cooling held off until cleared
// - supply alarm after bypass time; switch to cooling, end at once
// - stuck open and stuck closed valve alarms from inlet temperature
// - lid alarm only with switch fitted and open past alarm time
// - power failure below 16 V or total loss; ends above 21 V
// - total loss reported once at power-down, logged at next start-up
// - total loss event suppressed after restart request
// - battery event follows running on battery power
// - low battery after time below 21 V on battery; ends above 21 V
// - mute toggles on press and ends after 30 minutes
// - log request on every event change and every log interval
module cfe_event_supervisor #(
  parameter int unsigned TICK_CYC = `CFE_TICK_CYC
) (
  // clock and reset
  input  wire logic                i_sys_clk,
  input  wire logic                i_arst_n,
  // sensors and setup
  input  wire cfe_pkg::cfe_sense_s i_sense,
  input  wire cfe_pkg::cfe_cfg_s   i_cfg,
  // operator and power requests
  input  wire logic                i_ct_clear,
  input  wire logic                i_restart_req,
  input  wire logic                i_pf_boot_pending,
  // valves
  output logic                     o_cool_valve,
  output logic                     o_bypass_valve,
  // events and log
  output cfe_pkg::cfe_evt_s        o_events,
  output logic                     o_log_req,
  output logic                     o_pf_report,
  output logic                     o_pf_store
);
  import cfe_pkg::*;

  localparam int T_COIL  = 0;
  localparam int T_INLET = 1;
  localparam int T_AF    = 2;
  localparam int T_BF    = 3;
  localparam int T_AL    = 4;
  localparam int T_AH    = 5;
  localparam int T_BL    = 6;
  localparam int T_BH    = 7;
  localparam int T_CT    = 8;
  localparam int T_SUP   = 9;
  localparam int T_SO    = 10;
  localparam int T_SC    = 11;
  localparam int T_LID   = 12;
  localparam int T_BATT  = 13;
  localparam int N_TMR   = 14;

  function automatic logic lt_s(input cfe_temp_t a, input cfe_temp_t b);
    return a < b;
  endfunction

  logic [24:0]        tick_cnt_ff;
  logic               tick_ff;
  logic [N_TMR-1:0]   tm_cond;
  logic [N_TMR-1:0]   tm_done;
  cfe_secs_t          tm_lim [N_TMR];
  cfe_mode_e          mode_ff;
  cfe_mode_e          nxt_mode;
  cfe_evt_s           evt_ff;
  cfe_evt_s           nxt_evt;
  cfe_temp_t          chamber;
  logic signed [16:0] cool_floor;
  logic               warm;
  logic               below_max;
  logic               coil_cold;
  logic               inlet_hot;
  logic               inlet_cold;
  logic               cool_exit;
  logic               cool_block;
  logic               bypass_ok;
  logic               valves_open;
  logic               pf_low;
  logic               supply_hi;
  logic               restart_armed_ff;
  logic               gone_ff;
  logic               loss_edge;
  logic               pf_set;
  logic               pf_ff;
  logic               pf_report_ff;
  logic               pf_store_ff;
  logic               boot_seen_ff;
  logic               boot_log;
  logic               bv_ff;
  logic               mute_ff;
  logic [10:0]        mute_cnt_ff;
  cfe_secs_t          per_cnt_ff;
  logic               per_hit;
  logic               log_ff;

  // one second timebase
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tick_cnt_ff <= 25'h0000000;
      tick_ff     <= 1'b0;
    end else if (tick_cnt_ff == 25'(TICK_CYC - 1)) begin
      tick_cnt_ff <= 25'h0000000;
      tick_ff     <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 25'h0000001;
      tick_ff     <= 1'b0;
    end
  end

  // temperature comparisons
  assign chamber    = (i_cfg.a_en && i_sense.a_valid) ? i_sense.temp_a
                                                      : i_sense.temp_b;
  assign cool_floor = {i_cfg.max_chamber[15], i_cfg.max_chamber}
                    - {i_cfg.deadband[15], i_cfg.deadband};
  assign warm       = lt_s(i_cfg.max_chamber, chamber);
  assign below_max  = lt_s(chamber, i_cfg.max_chamber);
  assign coil_cold  = lt_s(i_sense.coil, i_cfg.coil_min);
  assign inlet_hot  = lt_s(i_cfg.inlet_sp, i_sense.inlet);
  assign inlet_cold = lt_s(i_sense.inlet, i_cfg.inlet_sp);
  assign cool_exit  = ($signed({chamber[15], chamber}) < cool_floor)
                   || coil_cold;
  assign cool_block = coil_cold || (i_cfg.bypass_en && inlet_hot);
  assign bypass_ok  = i_cfg.bypass_en && inlet_hot
                   && !evt_ff.inlet_fault;
  assign valves_open = (mode_ff == st_cool) || (mode_ff == st_bypass);

  // dwell timer conditions and limits
  always_comb begin
    tm_cond         = '0;
    tm_cond[T_COIL] = !i_sense.coil_valid;
    tm_cond[T_INLET] = !i_sense.inlet_valid;
    tm_cond[T_AF]   = !i_sense.a_valid;
    tm_cond[T_BF]   = !i_sense.b_valid;
    tm_cond[T_AL]   = i_cfg.a_en && lt_s(i_sense.temp_a, i_cfg.a_low);
    tm_cond[T_AH]   = i_cfg.a_en && lt_s(i_cfg.a_high, i_sense.temp_a);
    tm_cond[T_BL]   = i_cfg.b_en && lt_s(i_sense.temp_b, i_cfg.b_low);
    tm_cond[T_BH]   = i_cfg.b_en && lt_s(i_cfg.b_high, i_sense.temp_b);
    tm_cond[T_CT]   = i_cfg.ct_en && (mode_ff == st_cool);
    tm_cond[T_SUP]  = mode_ff == st_bypass;
    tm_cond[T_SO]   = !valves_open && inlet_cold;
    tm_cond[T_SC]   = valves_open && inlet_hot;
    tm_cond[T_LID]  = i_cfg.lid_fitted && i_sense.lid_open;
    tm_cond[T_BATT] = i_sense.on_battery && !supply_hi
                   && (i_sense.supply != `CFE_PF_HIGH_DV);
  end
  // low and high probe alarms end as soon as their condition drops

  always_comb begin
    tm_lim[T_COIL]  = i_cfg.coil_fail_t;
    tm_lim[T_INLET] = i_cfg.inlet_fail_t;
    tm_lim[T_AF]    = i_cfg.a_fail_t;
    tm_lim[T_BF]    = i_cfg.b_fail_t;
    tm_lim[T_AL]    = i_cfg.a_low_t;
    tm_lim[T_AH]    = i_cfg.a_high_t;
    tm_lim[T_BL]    = i_cfg.b_low_t;
    tm_lim[T_BH]    = i_cfg.b_high_t;
    tm_lim[T_CT]    = i_cfg.cool_t;
    tm_lim[T_SUP]   = i_cfg.supply_t;
    tm_lim[T_SO]    = i_cfg.stuck_open_t;
    tm_lim[T_SC]    = i_cfg.stuck_closed_t;
    tm_lim[T_LID]   = i_cfg.lid_t;
    tm_lim[T_BATT]  = i_cfg.batt_t;
  end

  for (genvar g = 0; g < N_TMR; g++) begin : g_tmr
    cfe_dwell_timer u_tmr (
      .i_sys_clk (i_sys_clk),
      .i_arst_n  (i_arst_n),
      .i_tick    (tick_ff),
      .i_cond    (tm_cond[g]),
      .i_limit   (tm_lim[g]),
      .o_done    (tm_done[g])
    );
  end

  // cooling and bypass state machine
  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      st_idle: begin
        if (below_max && bypass_ok) begin
          nxt_mode = st_bypass;
        end else if (warm && !cool_block) begin
          nxt_mode = st_cool;
        end
      end
      st_bypass: begin
        if (tm_done[T_SUP]) begin
          nxt_mode = st_cool;
        end else if (inlet_cold) begin
          nxt_mode = st_idle;
        end
      end
      st_cool: begin
        if (tm_done[T_CT]) begin
          nxt_mode = st_lockout;
        end else if (cool_exit) begin
          nxt_mode = st_idle;
        end
      end
      st_lockout: begin
        if (i_ct_clear) begin
          nxt_mode = st_idle;
        end
      end
      default: nxt_mode = st_idle;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_ff <= st_idle;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // power failure and total loss handling
  assign pf_low    = i_sense.supply < `CFE_PF_LOW_DV;
  assign supply_hi = i_sense.supply > `CFE_PF_HIGH_DV;
  assign loss_edge = i_sense.power_gone && !gone_ff
                  && !restart_armed_ff;
  assign pf_set    = pf_low || (i_sense.power_gone
                  && !restart_armed_ff);

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      restart_armed_ff <= 1'b0;
      gone_ff          <= 1'b0;
      pf_ff            <= 1'b0;
      pf_report_ff     <= 1'b0;
      pf_store_ff      <= 1'b0;
    end else begin
      gone_ff      <= i_sense.power_gone;
      pf_report_ff <= loss_edge;
      if (i_restart_req) begin
        restart_armed_ff <= 1'b1;
      end
      if (loss_edge) begin
        pf_store_ff <= 1'b1;
      end
      if (pf_set) begin
        pf_ff <= 1'b1;
      end else if (supply_hi) begin
        pf_ff <= 1'b0;
      end
    end
  end

  // start-up capture of a pending total loss
  assign boot_log = !boot_seen_ff && i_pf_boot_pending;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      boot_seen_ff <= 1'b0;
    end else begin
      boot_seen_ff <= 1'b1;
    end
  end

  // low battery latch
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bv_ff <= 1'b0;
    end else if (tm_done[T_BATT]) begin
      bv_ff <= 1'b1;
    end else if (supply_hi) begin
      bv_ff <= 1'b0;
    end
  end

  // alarm mute
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mute_ff     <= 1'b0;
      mute_cnt_ff <= 11'h000;
    end else if (i_sense.mute_press) begin
      mute_ff     <= !mute_ff;
      mute_cnt_ff <= 11'h000;
    end else if (mute_ff && tick_ff) begin
      if (mute_cnt_ff == 11'(`CFE_MUTE_TICKS - 1)) begin
        mute_ff <= 1'b0;
      end
      mute_cnt_ff <= mute_cnt_ff + 11'h001;
    end
  end

  // event vector
  always_comb begin
    nxt_evt                          = '0;
    nxt_evt.cooling                  = nxt_mode == st_cool;
    nxt_evt.bypassing                = nxt_mode == st_bypass;
    nxt_evt.coil_sensor_fault_event  = tm_done[T_COIL];
    nxt_evt.inlet_fault              = tm_done[T_INLET];
    nxt_evt.probe_a_fault_event      = tm_done[T_AF];
    nxt_evt.probe_b_fault_event      = tm_done[T_BF];
    nxt_evt.probe_a_low_event        = tm_done[T_AL];
    nxt_evt.probe_a_high             = tm_done[T_AH];
    nxt_evt.probe_b_low_event        = tm_done[T_BL];
    nxt_evt.probe_b_high             = tm_done[T_BH];
    nxt_evt.cool_time                = nxt_mode == st_lockout;
    nxt_evt.supply_timeout_event     = (mode_ff == st_bypass)
                                    && tm_done[T_SUP];
    nxt_evt.stuck_open               = tm_done[T_SO];
    nxt_evt.valve_stuck_closed_event = tm_done[T_SC];
    nxt_evt.lid_ajar_event           = tm_done[T_LID];
    nxt_evt.power_loss_event         = pf_ff;
    nxt_evt.on_battery               = i_sense.on_battery;
    nxt_evt.battery_low_event        = bv_ff;
    nxt_evt.muted                    = mute_ff;
  end

  // periodic log interval
  assign per_hit = tick_ff && (i_cfg.log_t != 16'h0000)
                && (per_cnt_ff >= i_cfg.log_t - 16'h0001);

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      per_cnt_ff <= 16'h0000;
    end else if (per_hit) begin
      per_cnt_ff <= 16'h0000;
    end else if (tick_ff) begin
      per_cnt_ff <= per_cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      evt_ff <= '0;
      log_ff <= 1'b0;
    end else begin
      evt_ff <= nxt_evt;
      log_ff <= (nxt_evt != evt_ff) || per_hit || boot_log;
    end
  end

  assign o_events       = evt_ff;
  assign o_cool_valve   = evt_ff.cooling;
  assign o_bypass_valve = evt_ff.bypassing;
  assign o_log_req      = log_ff;
  assign o_pf_report    = pf_report_ff;
  assign o_pf_store     = pf_store_ff;

  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);

  cool_entry_a: assert property (
    (mode_ff == st_idle && warm && !cool_block && !bypass_ok)
      |=> (mode_ff == st_cool) ##0 o_cool_valve)
    else $error("cooling not entered");
  cool_block_a: assert property (
    (mode_ff == st_idle && cool_block) |=> (mode_ff != st_cool))
    else $error("cooling entered while blocked");
  cool_exit_a: assert property (
    (mode_ff == st_cool && cool_exit && !tm_done[T_CT])
      |=> (mode_ff == st_idle) ##0 !o_cool_valve)
    else $error("cooling not ended");
  byp_entry_a: assert property (
    (mode_ff == st_idle && below_max && bypass_ok)
      |=> (mode_ff == st_bypass) ##0 o_bypass_valve)
    else $error("bypass not entered");
  byp_block_a: assert property (
    (mode_ff == st_idle && !bypass_ok) |=> (mode_ff != st_bypass))
    else $error("bypass entered while blocked");
  byp_end_a: assert property (
    (mode_ff == st_bypass && inlet_cold && !tm_done[T_SUP])
      |=> (mode_ff == st_idle))
    else $error("bypass not ended");
  coil_fault_a: assert property (
    $rose(o_events.coil_sensor_fault_event)
      |-> !$past(i_sense.coil_valid, 2))
    else $error("coil fault without bad reading");
  ct_hold_a: assert property (
    (mode_ff == st_lockout && !i_ct_clear)
      |=> (mode_ff == st_lockout) ##1 !o_cool_valve)
    else $error("cooling left lockout uncleared");
  supply_a: assert property (
    (mode_ff == st_bypass && tm_done[T_SUP])
      |=> (mode_ff == st_cool && o_events.supply_timeout_event)
      ##1 !o_events.supply_timeout_event)
    else $error("supply alarm sequence wrong");
  pf_end_a: assert property (
    (supply_hi && !pf_set)[*2] |=> !o_events.power_loss_event)
    else $error("power event held above high level");
  mute_len_a: assert property (
    mute_ff |-> (mute_cnt_ff < 11'(`CFE_MUTE_TICKS)))
    else $error("mute outlasted its limit");
  log_chg_a: assert property (
    (o_events != $past(o_events)) |-> o_log_req)
    else $error("event change not logged");

  cool_seen_c:   cover property ($rose(o_cool_valve));
  sup_switch_c:  cover property (o_events.supply_timeout_event);
  mute_seen_c:   cover property ($rose(o_events.muted));
  pf_report_c:   cover property (o_pf_report);

endmodule

// File: rtl/cfe_map.svh
`ifndef CFE_MAP_SVH
`define CFE_MAP_SVH

// system clock rate and timebase
`define CFE_CLK_HZ        20000000
`define CFE_TICK_MS       1000
`define CFE_TICK_CYC      (`CFE_CLK_HZ / 1000 * `CFE_TICK_MS)

// supply thresholds in tenths of a volt
`define CFE_PF_LOW_DV     10'h0A0
`define CFE_PF_HIGH_DV    10'h0D2

// mute length
`define CFE_MUTE_MIN      30
`define CFE_MUTE_TICKS    (`CFE_MUTE_MIN * 60)

// suggested setup defaults, seconds
`define CFE_DEF_ALARM_S   16'h003C
`define CFE_DEF_SUPPLY_S  16'h012C

`endif

// File: rtl/cfe_pkg.sv
package cfe_pkg;

  typedef logic signed [15:0] cfe_temp_t;
  typedef logic [15:0]        cfe_secs_t;
  typedef logic [9:0]         cfe_volt_t;

  typedef enum logic [1:0] {
    st_idle    = 2'b00,
    st_bypass  = 2'b01,
    st_cool    = 2'b10,
    st_lockout = 2'b11
  } cfe_mode_e;

  typedef struct packed {
    cfe_temp_t temp_a;
    cfe_temp_t temp_b;
    cfe_temp_t coil;
    cfe_temp_t inlet;
    logic      a_valid;
    logic      b_valid;
    logic      coil_valid;
    logic      inlet_valid;
    cfe_volt_t supply;
    logic      on_battery;
    logic      lid_open;
    logic      mute_press;
    logic      power_gone;
  } cfe_sense_s;

  typedef struct packed {
    cfe_temp_t max_chamber;
    cfe_temp_t deadband;
    cfe_temp_t coil_min;
    cfe_temp_t inlet_sp;
    cfe_temp_t a_low;
    cfe_temp_t a_high;
    cfe_temp_t b_low;
    cfe_temp_t b_high;
    logic      bypass_en;
    logic      ct_en;
    logic      a_en;
    logic      b_en;
    logic      lid_fitted;
    cfe_secs_t coil_fail_t;
    cfe_secs_t inlet_fail_t;
    cfe_secs_t a_fail_t;
    cfe_secs_t b_fail_t;
    cfe_secs_t a_low_t;
    cfe_secs_t a_high_t;
    cfe_secs_t b_low_t;
    cfe_secs_t b_high_t;
    cfe_secs_t cool_t;
    cfe_secs_t supply_t;
    cfe_secs_t stuck_open_t;
    cfe_secs_t stuck_closed_t;
    cfe_secs_t lid_t;
    cfe_secs_t batt_t;
    cfe_secs_t log_t;
  } cfe_cfg_s;

  typedef struct packed {
    logic cooling;
    logic bypassing;
    logic coil_sensor_fault_event;
    logic inlet_fault;
    logic probe_a_fault_event;
    logic probe_b_fault_event;
    logic probe_a_low_event;
    logic probe_a_high;
    logic probe_b_low_event;
    logic probe_b_high;
    logic cool_time;
    logic supply_timeout_event;
    logic stuck_open;
    logic valve_stuck_closed_event;
    logic lid_ajar_event;
    logic power_loss_event;
    logic on_battery;
    logic battery_low_event;
    logic muted;
  } cfe_evt_s;

endpackage

// File: rtl/cfe_dwell_timer.sv
`timescale 1ns/1ps
module cfe_dwell_timer (
  // clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_arst_n,
  // timebase and condition
  input  wire logic              i_tick,
  input  wire logic              i_cond,
  input  wire cfe_pkg::cfe_secs_t i_limit,
  // result
  output logic                   o_done
);
  import cfe_pkg::*;

  cfe_secs_t cnt_ff;

  // counts ticks while the condition holds, restarts when it drops
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_ff <= 16'h0000;
    end else if (!i_cond) begin
      cnt_ff <= 16'h0000;
    end else if (i_tick && (cnt_ff < i_limit)) begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end

  assign o_done = i_cond && (cnt_ff >= i_limit);

endmodule

// File: tb/cfe_log_model.sv
`timescale 1ns/1ps
module cfe_log_model (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_arst_n,
  // log side of the supervisor
  input  wire logic        i_log_req,
  input  wire logic        i_pf_store,
  // entries and stored flag
  output logic [15:0]      o_entries,
  output logic             o_pf_flag
);
  initial o_pf_flag = 1'b0;

  // one entry for each request
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_entries <= 16'h0000;
    end else if (i_log_req) begin
      o_entries <= o_entries + 16'h0001;
    end
  end

  // nonvolatile flag, kept through reset
  always @(posedge i_sys_clk) begin
    if (i_pf_store) begin
      o_pf_flag <= 1'b1;
    end
  end
endmodule

// File: tb/cfe_event_supervisor_test.sv
`timescale 1ns/1ps
module cfe_event_supervisor_test;
  import cfe_pkg::*;
  logic        clk;
  logic        rst_n;
  cfe_sense_s  sn;
  cfe_cfg_s    cf;
  logic        pf_pend;
  logic        cool_v;
  logic        byp_v;
  logic        ct_clr;
  logic        rst_req;
  logic        pf_rep;
  logic        pf_sto;
  logic        log_req;
  cfe_evt_s    ev;
  cfe_evt_s    e;
  cfe_evt_s    exp_q[$];
  logic [15:0] entries;
  int          n_errors;
  int          total_checks;
  int          n_exp;
  int          n_seen;
  int          n_rep;
  int          cyc;

  cfe_event_supervisor #(.TICK_CYC(4)) dut_u (
    .i_sys_clk(clk), .i_arst_n(rst_n), .i_sense(sn), .i_cfg(cf),
    .i_ct_clear(ct_clr), .i_restart_req(rst_req), .i_pf_boot_pending(pf_pend),
    .o_cool_valve(cool_v), .o_bypass_valve(byp_v), .o_events(ev),
    .o_log_req(log_req), .o_pf_report(pf_rep), .o_pf_store(pf_sto));

  cfe_log_model log_u (
    .i_sys_clk(clk), .i_arst_n(rst_n), .i_log_req(log_req),
    .i_pf_store(pf_sto), .o_entries(entries), .o_pf_flag(pf_pend));

  initial clk = 1'b0;
  always #25 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, x, s);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask

  task automatic note(input cfe_evt_s v);
    exp_q.push_back(v);
    n_exp++;
  endtask

  task automatic wait_logs(input string nm);
    int i;
    i = 0;
    while (n_seen < n_exp && i < 10000) begin
      @(posedge clk);
      #1;
      i++;
    end
    #4;
    chk("log count", n_seen, n_exp);
    $display("test %s done", nm);
  endtask

  task automatic press();
    sn.mute_press = 1'b1;
    tick(1);
    sn.mute_press = 1'b0;
  endtask

  // monitor: each log entry carries the next noted event vector
  always @(negedge clk) begin
    cyc++;
    if (rst_n && log_req === 1'b1) begin
      n_seen++;
      if (exp_q.size() == 0) begin
        chk("unexpected log", 32'h1, 32'h0);
      end else begin
        chk("events", 32'(ev), 32'(exp_q.pop_front()));
      end
    end
    if (rst_n && pf_rep === 1'b1) begin
      n_rep++;
    end
    if (cyc > 40000) begin
      n_errors++;
      finish_test();
    end
  end

  initial begin
    void'($urandom(1970));
    rst_n = 1'b0;
    ct_clr = 1'b0;
    rst_req = 1'b0;
    sn = '0;
    sn.temp_a = -16'sd1700;
    sn.temp_b = -16'sd1700;
    sn.coil = -16'sd300;
    sn.inlet = -16'sd1100;
    {sn.a_valid, sn.b_valid, sn.coil_valid, sn.inlet_valid} = 4'hF;
    sn.supply = 10'h0F0;
    cf = '0;
    cf.max_chamber = -16'sd1500;
    cf.deadband = 16'sd50;
    cf.coil_min = -16'sd600;
    cf.inlet_sp = -16'sd1000;
    {cf.a_low, cf.b_low} = {2{-16'sd1900}};
    {cf.a_high, cf.b_high} = {2{-16'sd1350}};
    {cf.a_en, cf.b_en} = 2'h3;
    {cf.coil_fail_t, cf.inlet_fail_t, cf.a_fail_t, cf.b_fail_t} = {4{16'h0002}};
    {cf.a_low_t, cf.a_high_t, cf.b_low_t, cf.b_high_t} = {4{16'h0002}};
    {cf.lid_t, cf.batt_t, cf.supply_t} = {16'h0002, 16'h0002, 16'h0100};
    {cf.cool_t, cf.stuck_open_t, cf.stuck_closed_t} = {3{16'hFFFF}};
    repeat (3) @(posedge clk);
    #5;
    rst_n = 1'b1;
    tick(3);
    e = '0;
    sn.temp_a = 16'(-1499 + int'($urandom % 100));
    e.cooling = 1'b1;
    note(e);
    wait_logs("cool enter");
    sn.temp_a = -16'sd1560;
    e.cooling = 1'b0;
    note(e);
    wait_logs("cool exit");
    sn.coil = -16'sd700;
    sn.temp_a = -16'sd1400;
    tick(20);
    chk("cool valve", 32'(cool_v), 32'h0);
    sn.coil = -16'sd300;
    e.cooling = 1'b1;
    note(e);
    wait_logs("coil unblock");
    chk("cool valve", 32'(cool_v), 32'h1);
    sn.coil = -16'sd700;
    e.cooling = 1'b0;
    note(e);
    wait_logs("cold coil");
    sn.coil = -16'sd300;
    sn.temp_a = -16'sd1700;
    cf.bypass_en = 1'b1;
    sn.inlet = -16'sd500;
    e.bypassing = 1'b1;
    note(e);
    wait_logs("bypass");
    chk("bypass valve", 32'(byp_v), 32'h1);
    sn.inlet = -16'sd1100;
    e.bypassing = 1'b0;
    note(e);
    wait_logs("bypass end");
    chk("bypass valve", 32'(byp_v), 32'h0);
    cf.supply_t = 16'h0002;
    sn.temp_a = -16'sd1520;
    sn.inlet = -16'sd500;
    e.bypassing = 1'b1;
    note(e);
    {e.bypassing, e.cooling, e.supply_timeout_event} = 3'h3;
    note(e);
    e.supply_timeout_event = 1'b0;
    note(e);
    wait_logs("supply");
    cf.bypass_en = 1'b0;
    sn.temp_a = -16'sd1700;
    sn.inlet = -16'sd1100;
    e = '0;
    note(e);
    wait_logs("supply end");
    sn.temp_a = -16'sd2000;
    e.probe_a_low_event = 1'b1;
    note(e);
    wait_logs("a low");
    cf.a_en = 1'b0;
    e = '0;
    note(e);
    wait_logs("a off");
    sn.temp_a = -16'sd1700;
    cf.a_en = 1'b1;
    sn.temp_b = -16'sd1300;
    e.probe_b_high = 1'b1;
    note(e);
    wait_logs("b high");
    sn.temp_b = -16'sd1700;
    e = '0;
    note(e);
    sn.coil_valid = 1'b0;
    e.coil_sensor_fault_event = 1'b1;
    note(e);
    wait_logs("coil fault");
    sn.coil_valid = 1'b1;
    e = '0;
    note(e);
    wait_logs("coil valid");
    sn.lid_open = 1'b1;
    tick(20);
    chk("lid no switch", 32'(ev.lid_ajar_event), 32'h0);
    cf.lid_fitted = 1'b1;
    e.lid_ajar_event = 1'b1;
    note(e);
    wait_logs("lid");
    sn.lid_open = 1'b0;
    e = '0;
    note(e);
    wait_logs("lid shut");
    sn.supply = 10'h096;
    e.power_loss_event = 1'b1;
    note(e);
    wait_logs("low supply");
    sn.supply = 10'h0C8;
    tick(20);
    sn.supply = 10'h0DC;
    e = '0;
    note(e);
    wait_logs("supply back");
    sn.on_battery = 1'b1;
    sn.supply = 10'h0C8;
    e.on_battery = 1'b1;
    note(e);
    e.battery_low_event = 1'b1;
    note(e);
    wait_logs("battery low");
    sn.supply = 10'h0DC;
    e.battery_low_event = 1'b0;
    note(e);
    wait_logs("battery ok");
    sn.on_battery = 1'b0;
    e = '0;
    note(e);
    wait_logs("mains");
    cf.ct_en = 1'b1;
    cf.cool_t = 16'h0002;
    sn.temp_a = -16'sd1400;
    e.cooling = 1'b1;
    note(e);
    {e.cooling, e.cool_time} = 2'h1;
    note(e);
    wait_logs("cool time");
    tick(10);
    chk("lockout valve", 32'(cool_v), 32'h0);
    sn.temp_a = -16'sd1700;
    ct_clr = 1'b1;
    tick(1);
    ct_clr = 1'b0;
    e.cool_time = 1'b0;
    note(e);
    wait_logs("ct clear");
    for (int k = 0; k < 2; k++) begin
      press();
      e.muted = 1'b1;
      note(e);
      if (k == 0) begin
        wait_logs("mute");
        press();
      end
      e.muted = 1'b0;
      note(e);
      wait_logs("unmute");
    end
    sn.power_gone = 1'b1;
    e.power_loss_event = 1'b1;
    note(e);
    wait_logs("power gone");
    chk("pf store", 32'(pf_sto), 32'h1);
    chk("pf reports", n_rep, 1);
    tick(2);
    chk("entries", 32'(entries), n_exp);
    rst_n = 1'b0;
    sn.power_gone = 1'b0;
    tick(3);
    e = '0;
    note(e);
    rst_n = 1'b1;
    wait_logs("boot log");
    chk("boot entries", 32'(entries), 32'h1);
    rst_req = 1'b1;
    tick(1);
    rst_req = 1'b0;
    sn.power_gone = 1'b1;
    tick(10);
    chk("pf suppressed", n_rep, 1);
    chk("pf store off", 32'(pf_sto), 32'h0);
    finish_test();
  end
endmodule
